// >>> common/txpa_regs.svh
`ifndef TXPA_REGS_SVH
`define TXPA_REGS_SVH
// register indices (printed offsets are not all multiples of four)
`define TXPA_IDX_PATH_CTRL 8'h16
`define TXPA_IDX_PWR_WORD 8'h05
`define TXPA_IDX_PA_CFG 8'h20
`define TXPA_IDX_STATUS 8'h21
// byte address = index * 4
`define TXPA_ADDR_PATH_CTRL 10'h058
`define TXPA_ADDR_PWR_WORD 10'h014
`define TXPA_ADDR_PA_CFG 10'h080
`define TXPA_ADDR_STATUS 10'h084
`define TXPA_ADDR_W 10
// field layout of transmit_path_control
`define TXPA_LT_HI 7
`define TXPA_LT_LO 6
`define TXPA_OFFS_HI 1
`define TXPA_OFFS_LO 0
`define TXPA_CTRL_RESET 8'h31
`define TXPA_PWR_RESET 8'h00
// lead time: 2 us per step, (code+1) steps
`define TXPA_LEAD_STEP_NS 2000
`define TXPA_CLK_PERIOD_NS 20
`define TXPA_LEAD_STEP_CYC (`TXPA_LEAD_STEP_NS / `TXPA_CLK_PERIOD_NS)
`define TXPA_CNT_W 10
`define TXPA_RESP_OKAY 2'h0
`define TXPA_RESP_SLVERR 2'h2
`endif

// >>> common/txpa_pkg.sv
package txpa_pkg;
    typedef enum logic [1:0] {
        TXPA_IDLE,
        TXPA_LEAD,
        TXPA_SEND
    } txpa_state_t;
endpackage

// >>> rtl/txpa_lead_timer.sv
`include "txpa_regs.svh"
// counts the pa lead interval; done pulses once when it elapses
module txpa_lead_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [1:0] lead_code,
    output logic done
);
    logic [`TXPA_CNT_W-1:0] cnt_r;
    logic busy_r;
    wire [`TXPA_CNT_W-1:0] step = `TXPA_CNT_W'(`TXPA_LEAD_STEP_CYC);
    // two cycles of the lead go to the done flop and the chip-start flop downstream,
    // so the count is trimmed to make pa enable lead the chip by exactly (code+1) steps
    wire [`TXPA_CNT_W-1:0] lead_cyc = `TXPA_CNT_W'(step * ({8'h00, lead_code} + 10'h001));
    wire [`TXPA_CNT_W-1:0] load_val = lead_cyc - 10'h002;
    wire at_end = busy_r && (cnt_r == `TXPA_CNT_W'(0));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= at_end;
            if (start) begin
                cnt_r <= load_val;
                busy_r <= 1'b1;
            end else if (at_end) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - `TXPA_CNT_W'(1);
            end
        end
    end
endmodule // txpa_lead_timer

// >>> rtl/txpa_top.sv
// Functional notes
// - pa enable rises ahead of the first transmit chip by 2, 4, 6 or 8 us per bits 7:6.
// - when enabled, pa enable is driven on a differential output pin pair.
// - offset bits 1:0 code 1 means 0 dB, 2 means +1 dB, 3 means +2 dB; code 0 is reserved.
// - the offset is added to the power control word and the sum goes to power adjust.
`include "txpa_regs.svh"
module txpa_top
    import txpa_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [`TXPA_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`TXPA_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_request,
    input wire logic tx_done,
    output logic tx_chip_start,
    output logic pa_enable,
    output logic [7:0] pa_power_adjust,
    output logic front_end_indicator_p,
    output logic front_end_indicator_n
);
    logic [7:0] ctrl_r;
    logic [7:0] tx_power_word_r;
    logic fe_out_en_r;
    txpa_state_t state_r;
    logic [1:0] offs_lat_r;
    logic aw_got_r, w_got_r;
    logic [`TXPA_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic lead_done;

    // write channel: address and data accepted independently
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (awaddr_r == `TXPA_ADDR_PATH_CTRL) && wstrb_r[0];
    wire wr_pwr = wr_go && (awaddr_r == `TXPA_ADDR_PWR_WORD) && wstrb_r[0];
    wire wr_cfg = wr_go && (awaddr_r == `TXPA_ADDR_PA_CFG) && wstrb_r[0];
    wire wr_hit = (awaddr_r == `TXPA_ADDR_PATH_CTRL) || (awaddr_r == `TXPA_ADDR_PWR_WORD)
        || (awaddr_r == `TXPA_ADDR_PA_CFG) || (awaddr_r == `TXPA_ADDR_STATUS);
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire rd_hit = (s_axi_araddr == `TXPA_ADDR_PATH_CTRL) || (s_axi_araddr == `TXPA_ADDR_PWR_WORD)
        || (s_axi_araddr == `TXPA_ADDR_PA_CFG) || (s_axi_araddr == `TXPA_ADDR_STATUS);
    wire [31:0] status_word = {28'h0000000, offs_lat_r == 2'h0, pa_enable, tx_chip_start,
        state_r != TXPA_IDLE};
    wire [31:0] rd_mux =
        (s_axi_araddr == `TXPA_ADDR_PATH_CTRL) ? {24'h000000, ctrl_r} :
        (s_axi_araddr == `TXPA_ADDR_PWR_WORD) ? {24'h000000, tx_power_word_r} :
        (s_axi_araddr == `TXPA_ADDR_PA_CFG) ? {31'h00000000, fe_out_en_r} :
        (s_axi_araddr == `TXPA_ADDR_STATUS) ? status_word : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TXPA_RESP_OKAY;
        end else if (ce) begin
            if (aw_fire) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `TXPA_RESP_OKAY : `TXPA_RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `TXPA_RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `TXPA_RESP_OKAY : `TXPA_RESP_SLVERR;
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // reserved bits are plain storage; code 0 of the offset is stored as written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `TXPA_CTRL_RESET;
            tx_power_word_r <= `TXPA_PWR_RESET;
            fe_out_en_r <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_r <= wdata_r[7:0];
            end
            if (wr_pwr) begin
                tx_power_word_r <= wdata_r[7:0];
            end
            if (wr_cfg) begin
                fe_out_en_r <= wdata_r[0];
            end
        end
    end

    // transmit sequencer: latch settings, lead the pa, then release chips
    wire start_tx = (state_r == TXPA_IDLE) && tx_request;

    txpa_lead_timer u_lead (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(start_tx),
        .lead_code(ctrl_r[`TXPA_LT_HI:`TXPA_LT_LO]),
        .done(lead_done)
    );

    // wraps modulo 256, as an 8-bit adjust word; software avoids the wrap
    wire [7:0] adj_sum = 8'(tx_power_word_r + {6'h00, offs_lat_r});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= TXPA_IDLE;
            offs_lat_r <= 2'h1;
            pa_enable <= 1'b0;
            tx_chip_start <= 1'b0;
            pa_power_adjust <= 8'h00;
            front_end_indicator_p <= 1'b0;
            front_end_indicator_n <= 1'b0;
        end else if (ce) begin
            pa_power_adjust <= adj_sum;
            front_end_indicator_p <= fe_out_en_r && pa_enable;
            front_end_indicator_n <= fe_out_en_r && !pa_enable;
            tx_chip_start <= 1'b0;
            case (state_r)
                TXPA_IDLE: begin
                    if (tx_request) begin
                        offs_lat_r <= ctrl_r[`TXPA_OFFS_HI:`TXPA_OFFS_LO];
                        pa_enable <= 1'b1;
                        state_r <= TXPA_LEAD;
                    end
                end
                TXPA_LEAD: begin
                    if (lead_done) begin
                        tx_chip_start <= 1'b1;
                        state_r <= TXPA_SEND;
                    end
                end
                TXPA_SEND: begin
                    if (tx_done) begin
                        pa_enable <= 1'b0;
                        state_r <= TXPA_IDLE;
                    end
                end
                default: state_r <= TXPA_IDLE;
            endcase
        end
    end
endmodule // txpa_top

// >>> sim/txpa_props.sv
module txpa_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_request,
    input wire logic tx_done,
    input wire logic tx_chip_start,
    input wire logic pa_enable,
    input wire logic front_end_indicator_p,
    input wire logic front_end_indicator_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles of pa enable seen so far; saturates so a stuck enable cannot wrap
    logic [9:0] lead_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !pa_enable) begin
            lead_r <= 10'h000;
        end else if (ce && lead_r != 10'h3FF) begin
            lead_r <= lead_r + 10'h001;
        end
    end
    a_pa_on_request: assert property (ce && tx_request && !pa_enable |=> pa_enable)
        else $error("pa enable missed a request");
    a_lead_exact: assert property (tx_chip_start |-> lead_r == 10'h064 || lead_r == 10'h0C8
        || lead_r == 10'h12C || lead_r == 10'h190) else $error("lead time off");
    a_chip_pulse: assert property (tx_chip_start && ce |=> !tx_chip_start)
        else $error("chip start longer than one cycle");
    a_chip_in_pa: assert property (tx_chip_start |-> pa_enable)
        else $error("chip start without pa enable");
    a_pa_hold: assert property (pa_enable && !tx_done |=> pa_enable)
        else $error("pa enable dropped early");
    a_fe_pair: assert property (front_end_indicator_p |->
        !front_end_indicator_n && $past(pa_enable)) else $error("front end pair wrong");
    a_fe_low: assert property (front_end_indicator_n |-> !$past(pa_enable))
        else $error("front end low side wrong");
    a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // txpa_props
bind txpa_top txpa_props txpa_props_inst (.*);

// >>> sim/txpa_fe_model.sv
// front end partner: ends the frame a chosen number of cycles after the first chip
module txpa_fe_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_chip_start,
    input wire logic [7:0] frame_len,
    output logic tx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] left_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            left_r <= 9'h000;
            tx_done <= 1'b0;
        end else begin
            tx_done <= (left_r == 9'h001);
            if (tx_chip_start) begin
                left_r <= {1'b0, frame_len} + 9'h001;
            end else if (left_r != 9'h000) begin
                left_r <= left_r - 9'h001;
            end
        end
    end
endmodule // txpa_fe_model

// >>> sim/testbench.sv
`include "txpa_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, ce, tx_request, tx_done, tx_chip_start, pa_enable;
    logic front_end_indicator_p, front_end_indicator_n;
    logic [7:0] pa_power_adjust, frame_len, word, adj;
    logic [`TXPA_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, code, offs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] rq[$], tq[$];
    int n_mismatch, checked, lead, i;
    wire [20:0] chip_obs = {front_end_indicator_p, pa_power_adjust, lead[11:0]};
    txpa_top txpa_top_inst (.*);
    txpa_fe_model txpa_fe_model_inst (.*);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // recommended words only pair with their mode's offset: 2 with the boost-mode
    // o-qpsk words, 3 with the linear bpsk words; offset 1 gets a raw random word
    function automatic logic [7:0] pick_word(input logic [1:0] o, input logic [31:0] s);
        logic [7:0] boost_w[4];
        logic [7:0] linear_w[4];
        boost_w = '{8'hC1, 8'hE3, 8'hE4, 8'hC5};
        linear_w = '{8'hE8, 8'hE9, 8'hEA, 8'hCB};
        case (o)
            2'h2: return boost_w[s[1:0]];
            2'h3: return linear_w[s[1:0]];
            default: return s[7:0];
        endcase
    endfunction
    task automatic finish_test(input bit timed_out);
        if (timed_out) n_mismatch++;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (k == 50) finish_test(1);
        `CHK(s_axi_bresp, `TXPA_RESP_OKAY)
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        rq.push_back(e);
        for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (k == 50) finish_test(1);
        `CHK(s_axi_rresp, r)
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // results are judged here, away from the drivers that queued them
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready) `CHK(s_axi_rdata, rq.pop_front())
        if (tx_chip_start === 1'b1) `CHK(chip_obs, tq.pop_front())
        lead = (pa_enable === 1'b1) ? lead + 1 : 0;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_request} = 5'h00;
        {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
        {s_axi_awaddr, s_axi_araddr} = 20'h00000;
        s_axi_wdata = 32'h00000000;
        seed = 32'h0000EDB9;
        frame_len = 8'h03;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TXPA_ADDR_PATH_CTRL, 32'h00000031, `TXPA_RESP_OKAY);
        rd(`TXPA_ADDR_PWR_WORD, 32'h00000000, `TXPA_RESP_OKAY);
        rd(10'h3FC, 32'h00000000, `TXPA_RESP_SLVERR);
        // a request while frozen must not start anything
        ce <= 1'b0;
        tx_request <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(pa_enable, 1'b0)
        ce <= 1'b1;
        tx_request <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            code = k[1:0];
            offs = 2'(k % 3 + 1);
            seed = xs(seed);
            wr(`TXPA_ADDR_PA_CFG, {7'h00, k[0]});
            rd(`TXPA_ADDR_PA_CFG, {31'h00000000, k[0]}, `TXPA_RESP_OKAY);
            wr(`TXPA_ADDR_PATH_CTRL, {code, 4'hC, offs});
            rd(`TXPA_ADDR_PATH_CTRL, {24'h000000, code, 4'hC, offs}, `TXPA_RESP_OKAY);
            word = pick_word(offs, seed);
            wr(`TXPA_ADDR_PWR_WORD, word);
            frame_len <= seed[15:8] & 8'h3F;
            adj = word + {6'h00, offs};
            tq.push_back({k[0], adj, 12'((code + 1) * `TXPA_LEAD_STEP_CYC)});
            @(posedge aclk);
            tx_request <= 1'b1;
            @(posedge aclk);
            tx_request <= 1'b0;
            // new settings mid-frame must wait for the next start
            wr(`TXPA_ADDR_PATH_CTRL, {~code, 4'hC, 2'h3});
            rd(`TXPA_ADDR_STATUS, 32'h00000005, `TXPA_RESP_OKAY);
            for (i = 0; i < 1200 && pa_enable !== 1'b0; i++) @(posedge aclk);
            if (i == 1200) finish_test(1);
        end
        `CHK(tq.size(), 0)
        finish_test(0);
    end
endmodule // testbench
